/* agent_sink.sv */
// Behavioural model of the destination agents taking deliveries
`timescale 1ns/1ps
`default_nettype none

module agent_sink (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                dlv_valid,
  input  wire logic [remap_decode_pkg::AGENTS-1:0] dlv_target,
  input  wire logic                                dlv_level,
  output var  logic [7:0]                          taken,
  output var  logic [remap_decode_pkg::AGENTS-1:0] seen,
  output var  logic [remap_decode_pkg::AGENTS-1:0] pending
);
  import remap_decode_pkg::*;

  // ----------------------------------------------------------------
  // Receipt bookkeeping
  // ----------------------------------------------------------------
  // Each agent latches the delivery strobe; level work is left pending
  // here, since end-of-interrupt is beyond this block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taken   <= 8'h00;
      seen    <= '0;
      pending <= '0;
    end else if (dlv_valid) begin
      taken   <= taken + 8'h01;
      seen    <= seen | dlv_target;
      pending <= pending | (dlv_level ? dlv_target : '0);
    end
  end
endmodule : agent_sink

`default_nettype wire

/* decode_if.sv */
// Carrier between the request side and the entry field decoder
`timescale 1ns/1ps
`default_nettype none

interface decode_if;
  import remap_decode_pkg::*;

  logic [ENTRY_W-1:0]     entry;
  logic [AGENTS-1:0]      dest;
  logic [AGENT_IDX_W-1:0] rr_ptr;
  logic                   smi_ok;
  logic                   deliver;
  logic                   blocked;
  logic                   posted;
  logic                   misprog;
  logic                   level;
  logic                   vec_used;
  logic                   one_of_n;
  logic [AGENT_IDX_W-1:0] pick_idx;
  logic [AGENTS-1:0]      target;
  delivery_kind_t         kind;

  modport host (output entry, dest, rr_ptr, smi_ok,
                input  deliver, blocked, posted, misprog, level,
                       vec_used, one_of_n, pick_idx, target, kind);
  modport dec  (input  entry, dest, rr_ptr, smi_ok,
                output deliver, blocked, posted, misprog, level,
                       vec_used, one_of_n, pick_idx, target, kind);
endinterface : decode_if

`default_nettype wire

/* entry_decode.sv */
// Combinational decode of the delivery fields of one remap entry
`timescale 1ns/1ps
`default_nettype none

module entry_decode (
  decode_if.dec bus
);
  import remap_decode_pkg::*;

  // ----------------------------------------------------------------
  // Field extraction; the spare nibble is never looked at
  // ----------------------------------------------------------------
  wire logic [2:0]             kind_raw = bus.entry[KIND_HI:KIND_LO];
  wire logic                   valid    = bus.entry[VALID_BIT];
  wire logic                   posting  = bus.entry[POSTING_BIT];
  wire logic                   live     = ~posting & valid;
  wire logic                   known    = kind_known(kind_raw, bus.smi_ok);
  wire logic                   no_agent = ~|bus.dest;
  wire logic [AGENT_IDX_W:0]   pick     = pick_one(bus.dest, bus.rr_ptr);
  wire logic                   hint;
  wire logic                   force_edge;

  // Hint only read for live entries; it narrows fixed delivery to one
  assign hint = live & bus.entry[HINT_BIT];
  assign bus.kind = delivery_kind_t'(kind_raw);
  assign bus.one_of_n = (kind_raw == KIND_LOWEST) |
                        ((kind_raw == KIND_FIXED) & hint);
  assign bus.pick_idx = pick[AGENT_IDX_W-1:0];

  // Lone target when one of N, otherwise every named agent
  assign bus.target = bus.one_of_n ?
                      (AGENTS'(1) << pick[AGENT_IDX_W-1:0]) :
                      bus.dest;

  // Special kinds are edge only and carry no vector
  assign force_edge = (kind_raw == KIND_SMI) | (kind_raw == KIND_NMI) |
                      (kind_raw == KIND_INIT);
  assign bus.level  = live & ~force_edge &
                      (bus.entry[SENSE_BIT] == SENSE_LEVEL);
  assign bus.vec_used = live & ~force_edge;

  // Outcome classes, mutually exclusive
  assign bus.posted  = posting;
  assign bus.blocked = ~posting & ~valid;
  assign bus.misprog = live & (~known | no_agent);
  assign bus.deliver = live & known & ~no_agent;

endmodule : entry_decode

`default_nettype wire

/* remap_decode_pkg.sv */
// Shared constants, field layout and types for the remap entry decode
package remap_decode_pkg;

  // ----------------------------------------------------------------
  // Entry field layout (low word of a remap table entry)
  // ----------------------------------------------------------------
  localparam int ENTRY_W      = 16;
  localparam int POSTING_BIT  = 15;
  localparam int SPARE_HI     = 11;
  localparam int SPARE_LO     = 8;
  localparam int KIND_HI      = 7;
  localparam int KIND_LO      = 5;
  localparam int SENSE_BIT    = 4;
  localparam int HINT_BIT     = 3;
  localparam int VALID_BIT    = 0;
  localparam logic SENSE_EDGE  = 1'b0;
  localparam logic SENSE_LEVEL = 1'b1;

  // ----------------------------------------------------------------
  // Destination agents
  // ----------------------------------------------------------------
  localparam int AGENTS      = 8;
  localparam int AGENT_IDX_W = 3;

  typedef enum logic [2:0] {
    KIND_FIXED  = 3'b000,
    KIND_LOWEST = 3'b001,
    KIND_SMI    = 3'b010,
    KIND_RSVD3  = 3'b011,
    KIND_NMI    = 3'b100,
    KIND_INIT   = 3'b101,
    KIND_RSVD6  = 3'b110,
    KIND_RSVD7  = 3'b111
  } delivery_kind_t;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          COUNT_N       = 3;
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_STATUS    = 12'h004;
  localparam logic [11:0] OFF_DELIVERED = 12'h008;
  localparam logic [11:0] OFF_BLOCKED   = 12'h00C;
  localparam logic [11:0] OFF_MISPROG   = 12'h010;
  localparam int          CTRL_ENABLE_BIT = 0;
  localparam int          CTRL_SMI_BIT    = 1;
  localparam logic        CTRL_ENABLE_RST = 1'b1;
  localparam logic        CTRL_SMI_RST    = 1'b0;
  localparam int          ST_KIND_LO      = 0;
  localparam int          ST_LEVEL_BIT    = 3;
  localparam int          ST_TARGET_LO    = 4;
  localparam int          ST_MISPROG_BIT  = 12;
  localparam logic [31:0] CNT_ONE         = 32'h0000_0001;

  // Known kinds; system management support is a control register option
  function automatic logic kind_known(input logic [2:0] kind,
                                      input logic       smi_ok);
    case (kind)
      KIND_FIXED, KIND_LOWEST, KIND_NMI, KIND_INIT: kind_known = 1'b1;
      KIND_SMI: kind_known = smi_ok;
      default:  kind_known = 1'b0;
    endcase
  endfunction : kind_known

  // First set bit at or after start, wrapping; MSB flags a find
  function automatic logic [AGENT_IDX_W:0] pick_one(
      input logic [AGENTS-1:0]      mask,
      input logic [AGENT_IDX_W-1:0] start);
    logic [AGENT_IDX_W:0]   res;
    logic [AGENT_IDX_W-1:0] idx;
    res = '0;
    for (int i = AGENTS - 1; i >= 0; i--) begin
      idx = start + AGENT_IDX_W'(i);
      if (mask[idx]) res = {1'b1, idx};
    end
    return res;
  endfunction : pick_one

endpackage : remap_decode_pkg

/* remap_entry_delivery_decode.sv */
// Remap entry delivery decode with APB control, status and counters
//
// Behaviour
// - The four spare bits of an entry never affect how a request goes.
// - The three-bit delivery kind field selects how a request is handled.
// - Fixed kind with hint clear delivers to every named agent, edge or level.
// - Lowest priority kind delivers to exactly one named agent.
// - System management kind is edge only and its vector is unused.
// - Non-maskable kind goes to all named agents, edge only, no vector.
// - Initialisation kind goes to all named agents, edge only, no vector.
// - Trigger sense zero means edge, one means level.
// - Trigger sense is read only for entries marked valid.
// - With hint clear, fixed delivery goes to the agents as named.
// - With hint set, hardware chooses one of the named agents for fixed kind.
// - The hint is read only for entries marked valid.
// - Entries not marked valid block the request; valid ones proceed.
// - This decode serves only entries whose posting select is zero.
`timescale 1ns/1ps
`default_nettype none

module remap_entry_delivery_decode (
  input  wire logic                                    pclk,
  input  wire logic                                    presetn,
  input  wire logic                                    psel,
  input  wire logic                                    penable,
  input  wire logic                                    pwrite,
  input  wire logic [remap_decode_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [remap_decode_pkg::DATA_W-1:0]     pwdata,
  input  wire logic [3:0]                              pstrb,
  output logic      [remap_decode_pkg::DATA_W-1:0]     prdata,
  output logic                                         pready,
  output logic                                         pslverr,
  input  wire logic                                    req_valid,
  input  wire logic [remap_decode_pkg::ENTRY_W-1:0]    req_entry,
  input  wire logic [remap_decode_pkg::AGENTS-1:0]     req_dest,
  output logic                                         dlv_valid,
  output logic      [remap_decode_pkg::AGENTS-1:0]     dlv_target,
  output remap_decode_pkg::delivery_kind_t             dlv_kind,
  output logic                                         dlv_level,
  output logic                                         dlv_vector_used,
  output logic                                         blocked_pulse,
  output logic                                         posted_pulse,
  output logic                                         misprog_pulse
);
  import remap_decode_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                   ctrl_enable;
  logic                   ctrl_smi;
  logic [AGENT_IDX_W-1:0] rr_ptr;
  logic [2:0]             last_kind;
  logic                   last_level;
  logic [AGENTS-1:0]      last_target;
  logic                   last_misprog;
  logic [DATA_W-1:0]      cnt [COUNT_N];

  decode_if dec_bus ();

  // ----------------------------------------------------------------
  // Field decoder
  // ----------------------------------------------------------------
  // Requests come from same-clock lookup logic, so no synchroniser
  assign dec_bus.entry  = req_entry;
  assign dec_bus.dest   = req_dest;
  assign dec_bus.rr_ptr = rr_ptr;
  assign dec_bus.smi_ok = ctrl_smi;

  entry_decode u_decode (
    .bus (dec_bus.dec)
  );

  // ----------------------------------------------------------------
  // Request acceptance
  // ----------------------------------------------------------------
  // A disabled block drops requests silently; nothing is counted
  wire logic take      = req_valid & ctrl_enable;
  wire logic take_dlv  = take & dec_bus.deliver;
  wire logic take_blk  = take & dec_bus.blocked;
  wire logic take_post = take & dec_bus.posted;
  wire logic take_mis  = take & dec_bus.misprog;
  wire logic rotate    = take_dlv & dec_bus.one_of_n;
  wire logic [AGENT_IDX_W-1:0] next_rr_ptr =
    dec_bus.pick_idx + AGENT_IDX_W'(1);

  // Delivery outputs: one-cycle pulses except the kind, registered off the decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dlv_valid       <= 1'b0;
      dlv_target      <= '0;
      dlv_kind        <= KIND_FIXED;
      dlv_level       <= SENSE_EDGE;
      dlv_vector_used <= 1'b0;
      blocked_pulse   <= 1'b0;
      posted_pulse    <= 1'b0;
      misprog_pulse   <= 1'b0;
    end else begin
      dlv_valid       <= take_dlv;
      dlv_target      <= take_dlv ? dec_bus.target : '0;
      dlv_kind        <= dec_bus.kind;
      dlv_level       <= take_dlv & dec_bus.level;
      dlv_vector_used <= take_dlv & dec_bus.vec_used;
      blocked_pulse   <= take_blk;
      posted_pulse    <= take_post;
      misprog_pulse   <= take_mis;
    end
  end

  // Rotating start point spreads one-of-N deliveries across agents
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rr_ptr <= '0;
    end else if (rotate) begin
      rr_ptr <= next_rr_ptr;
    end
  end

  // Snapshot of the last delivered or misprogrammed request for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_kind    <= KIND_FIXED;
      last_level   <= SENSE_EDGE;
      last_target  <= '0;
      last_misprog <= 1'b0;
    end else if (take_dlv | take_mis) begin
      last_kind    <= dec_bus.kind;
      last_level   <= dec_bus.level;
      last_target  <= take_dlv ? dec_bus.target : '0;
      last_misprog <= take_mis;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state: pready rises in the second access cycle
  wire logic apb_access = psel & penable;
  wire logic apb_first  = apb_access & ~pready;
  wire logic apb_done   = apb_access & pready;
  wire logic aligned    = (paddr[1:0] == 2'b00);
  wire logic hit_ctrl   = aligned & (paddr == OFF_CTRL);
  wire logic hit_status = aligned & (paddr == OFF_STATUS);
  wire logic hit_dlv    = aligned & (paddr == OFF_DELIVERED);
  wire logic hit_blk    = aligned & (paddr == OFF_BLOCKED);
  wire logic hit_mis    = aligned & (paddr == OFF_MISPROG);
  wire logic mapped     = hit_ctrl | hit_status | hit_dlv |
                          hit_blk | hit_mis;
  wire logic wr_done    = apb_done & pwrite;
  wire logic ctrl_wr    = wr_done & hit_ctrl & pstrb[0];

  // Read words; unused bits read as zero
  wire logic [DATA_W-1:0] ctrl_word =
    (DATA_W'(ctrl_enable) << CTRL_ENABLE_BIT) |
    (DATA_W'(ctrl_smi)    << CTRL_SMI_BIT);
  wire logic [DATA_W-1:0] status_word =
    (DATA_W'(last_kind)    << ST_KIND_LO)   |
    (DATA_W'(last_level)   << ST_LEVEL_BIT) |
    (DATA_W'(last_target)  << ST_TARGET_LO) |
    (DATA_W'(last_misprog) << ST_MISPROG_BIT);
  wire logic [DATA_W-1:0] rd_word =
    ({DATA_W{hit_ctrl}}   & ctrl_word)   |
    ({DATA_W{hit_status}} & status_word) |
    ({DATA_W{hit_dlv}}    & cnt[0])      |
    ({DATA_W{hit_blk}}    & cnt[1])      |
    ({DATA_W{hit_mis}}    & cnt[2]);

  // Answer is captured in the first access cycle and held one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_first;
      prdata  <= (apb_first & ~pwrite) ? rd_word : '0;
      pslverr <= apb_first & ~mapped;
    end
  end

  // Control register; writes land on the completing edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_enable <= CTRL_ENABLE_RST;
      ctrl_smi    <= CTRL_SMI_RST;
    end else if (ctrl_wr) begin
      ctrl_enable <= pwdata[CTRL_ENABLE_BIT];
      ctrl_smi    <= pwdata[CTRL_SMI_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Event counters
  // ----------------------------------------------------------------
  // Any write to a counter's offset clears it; an event on the same edge still counts as one
  wire logic [COUNT_N-1:0] cnt_ev  = {take_mis, take_blk, take_dlv};
  wire logic [COUNT_N-1:0] cnt_clr = {wr_done & hit_mis,
                                      wr_done & hit_blk,
                                      wr_done & hit_dlv};

  for (genvar g = 0; g < COUNT_N; g++) begin : g_cnt
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt[g] <= '0;
      end else if (cnt_clr[g]) begin
        cnt[g] <= cnt_ev[g] ? CNT_ONE : '0;
      end else if (cnt_ev[g]) begin
        cnt[g] <= cnt[g] + CNT_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Expected delivery computed without the spare nibble
  wire logic [2:0] req_kind = req_entry[KIND_HI:KIND_LO];
  wire logic       req_live = req_entry[VALID_BIT] &
                              ~req_entry[POSTING_BIT];
  wire logic       exp_dlv  = take & req_live & (|req_dest) &
                              kind_known(req_kind, ctrl_smi);
  wire logic       req_special = (req_kind == KIND_SMI) |
                                 (req_kind == KIND_NMI) |
                                 (req_kind == KIND_INIT);

  chk_spare_ignored: assert property (
    1'b1 |=> dlv_valid == $past(exp_dlv))
    else $error("delivery depends on more than the decoded fields");

  chk_kind_passed: assert property (
    dlv_valid |-> dlv_kind == $past(req_entry[KIND_HI:KIND_LO]))
    else $error("delivered kind differs from entry kind");

  chk_fixed_all: assert property (
    take_dlv && req_kind == KIND_FIXED && !req_entry[HINT_BIT]
    |=> dlv_target == $past(req_dest))
    else $error("fixed delivery missed a named agent");

  chk_lowest_one: assert property (
    dlv_valid && dlv_kind == KIND_LOWEST
    |-> $onehot(dlv_target) && ((dlv_target & ~$past(req_dest)) == '0))
    else $error("lowest priority did not pick one named agent");

  chk_special_edge: assert property (
    take_dlv && req_special |=> dlv_valid && !dlv_level &&
                                !dlv_vector_used)
    else $error("special kind delivered as level or with vector");

  chk_special_all: assert property (
    take_dlv && (req_kind == KIND_NMI || req_kind == KIND_INIT)
    |=> dlv_target == $past(req_dest))
    else $error("broadcast kind missed a named agent");

  chk_init_target: assert property (
    dlv_valid && dlv_kind == KIND_INIT |-> !dlv_level &&
                                           dlv_target != '0)
    else $error("init delivery malformed");

  chk_sense_level: assert property (
    take_dlv && !req_special
    |=> dlv_level == $past(req_entry[SENSE_BIT]))
    else $error("trigger sense not honoured");

  chk_invalid_block: assert property (
    take && !req_entry[VALID_BIT] && !req_entry[POSTING_BIT]
    |=> blocked_pulse && !dlv_valid && !dlv_level)
    else $error("invalid entry not blocked");

  chk_hint_one: assert property (
    take_dlv && req_kind == KIND_FIXED && req_entry[HINT_BIT]
    |=> $onehot(dlv_target) && (dlv_target & ~$past(req_dest)) == '0)
    else $error("hinted delivery not narrowed to one agent");

  chk_hint_gated: assert property (
    take && !req_entry[VALID_BIT] && req_entry[HINT_BIT]
    |=> !$changed(rr_ptr) && dlv_target == '0)
    else $error("hint acted on an invalid entry");

  chk_posted_bypass: assert property (
    take && req_entry[POSTING_BIT]
    |=> posted_pulse && !dlv_valid && !misprog_pulse)
    else $error("posted entry went through remapped decode");

  chk_undefined_kind: assert property (
    take && req_live && !kind_known(req_kind, ctrl_smi)
    |=> misprog_pulse && !dlv_valid)
    else $error("undefined kind was delivered");

  chk_apb_answer: assert property (
    apb_first |=> pready ##1 !pready)
    else $error("APB answer not a single cycle after one wait");

  chk_fixed_named: assert property (
    dlv_valid && dlv_kind == KIND_FIXED && !$past(req_entry[HINT_BIT])
    |-> dlv_target == $past(req_dest))
    else $error("unhinted fixed delivery changed the agent set");

  chk_vector_fixed: assert property (
    take_dlv && !req_special
    |=> dlv_vector_used)
    else $error("fixed or lowest delivery dropped its vector");

  chk_quiet_outputs: assert property (
    !dlv_valid
    |-> !dlv_level && !dlv_vector_used && dlv_target == '0)
    else $error("delivery fields active without a delivery");

  chk_one_outcome: assert property (
    take
    |=> $onehot({dlv_valid, blocked_pulse, posted_pulse, misprog_pulse}))
    else $error("taken request lacks exactly one outcome");

  chk_idle_quiet: assert property (
    !take
    |=> !dlv_valid && !blocked_pulse && !posted_pulse && !misprog_pulse)
    else $error("outcome pulse without a taken request");

  chk_cnt_clear: assert property (
    wr_done && hit_dlv && !take_dlv
    |=> cnt[0] == '0)
    else $error("delivered count not cleared by a write");

  chk_ctrl_write: assert property (
    ctrl_wr
    |=> ctrl_enable == $past(pwdata[CTRL_ENABLE_BIT]) &&
        ctrl_smi == $past(pwdata[CTRL_SMI_BIT]))
    else $error("control write did not land");

  cov_lowest: cover property (dlv_valid && dlv_kind == KIND_LOWEST);
  cov_blocked: cover property (blocked_pulse);
  cov_posted: cover property (posted_pulse);
  cov_nmi: cover property (dlv_valid && dlv_kind == KIND_NMI);
  cov_misprog: cover property (misprog_pulse);

endmodule : remap_entry_delivery_decode

`default_nettype wire

/* tb.sv */
// Self-checking bench for the remap entry delivery decode
`timescale 1ns/1ps
`default_nettype none

module tb;
  import remap_decode_pkg::*;

  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, req_valid = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic [ENTRY_W-1:0] req_entry = '0;
  logic [AGENTS-1:0] req_dest = '0, dlv_target, seen, pending;
  delivery_kind_t dlv_kind;
  logic dlv_valid, dlv_level, dlv_vector_used, err;
  logic blocked_pulse, posted_pulse, misprog_pulse;
  logic [7:0] taken;
  int n_mismatch = 0, num_checks = 0;

  always #4 pclk = ~pclk;

  remap_entry_delivery_decode dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req_entry(req_entry),
    .req_dest(req_dest), .dlv_valid(dlv_valid), .dlv_target(dlv_target),
    .dlv_kind(dlv_kind), .dlv_level(dlv_level),
    .dlv_vector_used(dlv_vector_used), .blocked_pulse(blocked_pulse),
    .posted_pulse(posted_pulse), .misprog_pulse(misprog_pulse));

  agent_sink sink (.pclk(pclk), .presetn(presetn), .dlv_valid(dlv_valid),
    .dlv_target(dlv_target), .dlv_level(dlv_level), .taken(taken),
    .seen(seen), .pending(pending));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // Flags are {sense, hint, valid, posting}; the spare nibble always
  // carries a pattern, so it must not matter
  function automatic logic [15:0] mk(input logic [2:0] k,
                                     input logic [3:0] f);
    return {f[0], 3'h0, 4'hA, k, f[3], f[2], 2'h0, f[1]};
  endfunction : mk

  // Master holds the request until pready is sampled high; only the
  // watchdog ends a wait that never sees an answer
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One request; outcome code is {deliver, blocked, posted, misprog}
  task automatic send(input logic [15:0] e, input logic [7:0] dst,
                      input logic [3:0] oc, input logic [7:0] tg,
                      input logic [1:0] lv_vu);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_entry <= e;
    req_dest  <= dst;
    @(posedge pclk);
    req_valid <= 1'b0;
    req_entry <= ~e;
    req_dest  <= ~dst;
    #1;
    chk(32'({dlv_valid, blocked_pulse, posted_pulse, misprog_pulse}),
        32'(oc), "out");
    if (oc[3]) begin
      chk(32'(dlv_target), 32'(tg), "target");
      chk(32'({dlv_level, dlv_vector_used}), 32'(lv_vu), "sense/vec");
      chk(32'(dlv_kind), 32'(e[7:5]), "kind");
    end
  endtask : send

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(32'(err), 32'h0, "ctrl error");
    chk(rd, 32'h1, "ctrl reset");
    apb(1'b0, 12'h014, 32'h0);
    chk(32'(err), 32'h1, "unmapped");
    chk(rd, 32'h0, "unmapped data");
    $display("test regs done");
  endtask : t_regs

  task automatic t_kinds;
    send(mk(KIND_FIXED, 4'hA), 8'h0C, 4'h8, 8'h0C, 2'h3);
    send(mk(KIND_FIXED, 4'h2), 8'h05, 4'h8, 8'h05, 2'h1);
    send(mk(KIND_LOWEST, 4'h2), 8'h0C, 4'h8, 8'h04, 2'h1);
    send(mk(KIND_LOWEST, 4'hA), 8'h0C, 4'h8, 8'h08, 2'h3);
    send(mk(KIND_FIXED, 4'h6), 8'h30, 4'h8, 8'h10, 2'h1);
    send(mk(KIND_NMI, 4'hE), 8'h81, 4'h8, 8'h81, 2'h0);
    send(mk(KIND_INIT, 4'hA), 8'h42, 4'h8, 8'h42, 2'h0);
    $display("test kinds done");
  endtask : t_kinds

  // System management kind is misprogrammed until the control register enables it
  task automatic t_smi;
    send(mk(KIND_SMI, 4'hA), 8'h01, 4'h1, 8'h00, 2'h0);
    apb(1'b1, OFF_CTRL, 32'h3);
    send(mk(KIND_SMI, 4'hA), 8'h01, 4'h8, 8'h01, 2'h0);
    $display("test smi done");
  endtask : t_smi

  task automatic t_misc;
    send(mk(KIND_RSVD3, 4'h2), 8'h01, 4'h1, 8'h00, 2'h0);
    send(mk(KIND_RSVD6, 4'h2), 8'h01, 4'h1, 8'h00, 2'h0);
    send(mk(KIND_RSVD7, 4'h2), 8'h01, 4'h1, 8'h00, 2'h0);
    send(mk(KIND_FIXED, 4'hC), 8'h01, 4'h4, 8'h00, 2'h0);
    send(mk(KIND_FIXED, 4'h3), 8'h01, 4'h2, 8'h00, 2'h0);
    apb(1'b0, OFF_MISPROG, 32'h0);
    chk(rd, 32'h4, "misprog count");
    chk(32'({taken, seen, pending}), 32'h08_DF_0C, "agents");
    $display("test misc done");
  endtask : t_misc

  // Status snapshot, counter clear and a disabled block
  task automatic t_ctrl;
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h0000_1007, "status");
    apb(1'b0, OFF_DELIVERED, 32'h0);
    chk(rd, 32'h8, "delivered count");
    apb(1'b0, OFF_BLOCKED, 32'h0);
    chk(rd, 32'h1, "blocked count");
    apb(1'b1, OFF_DELIVERED, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h2);
    send(mk(KIND_FIXED, 4'h2), 8'h01, 4'h0, 8'h00, 2'h0);
    apb(1'b0, OFF_DELIVERED, 32'h0);
    chk(rd, 32'h0, "cleared count");
    apb(1'b1, OFF_CTRL, 32'h3);
    $display("test ctrl done");
  endtask : t_ctrl

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_kinds();
    t_smi();
    t_misc();
    t_ctrl();
    end_sim();
  end

  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    end_sim();
  end
endmodule : tb

`default_nettype wire
